// File: verilog/wcc_chopper_ctrl.v
/*
 current chopper for one winding bridge plus the fault supervisor
 that gates the bridge and drives the fault and stall report pins.
 assumes pins arrive asynchronous to mclk; comparators are digital.
*/
`timescale 1ns/1ns
`include "wcc_map.vh"
module wcc_chopper_ctrl #(
	parameter REF_W     = 8,
	parameter RETRY_CYC = `WCC_RETRY_CYC
) (
	// clock and reset
	input  wire             mclk,
	input  wire             resetn,
	// step interface pins
	input  wire             step,
	input  wire             direction,
	input  wire             sleep_n,
	// multi-level pins, {is_high, is_low} from pad comparators
	input  wire [1:0]       step_size_sel0_pad,
	input  wire [1:0]       step_size_sel1_pad,
	input  wire [1:0]       stall_mode_sel_pad,
	input  wire [1:0]       enable_pad,
	// current reference and comparators
	input  wire [REF_W-1:0] current_ref_level,
	input  wire [7:0]       valley_ratio,
	input  wire             trip_cmp,
	input  wire             valley_cmp,
	// fault sources
	input  wire             supply_undervoltage,
	input  wire             pump_undervoltage,
	input  wire             current_limit,
	input  wire             stall_detected,
	input  wire             learn_done,
	// bridge and pump
	output reg  [3:0]       bridge_gate,
	output reg              pump_enable,
	output reg  [REF_W-1:0] trip_level,
	output reg  [REF_W-1:0] valley_level,
	output reg              overcurrent_fault,
	output reg              stall_detect_enable,
	// decoded modes
	output reg  [1:0]       step_size_sel0,
	output reg  [1:0]       step_size_sel1,
	output reg  [1:0]       stall_mode_sel,
	output reg  [1:0]       enable_mode,
	// open-drain pins
	output reg              fault_n_out_o,
	output reg              fault_n_out_oe,
	input  wire             stall_report_i,
	output reg              stall_report_o,
	output reg              stall_report_oe
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam NS = 19;
	wire [NS-1:0] sy;

	wcc_sync #(.W(NS)) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      ({step, direction, sleep_n, step_size_sel0_pad, step_size_sel1_pad,
			  stall_mode_sel_pad, enable_pad, trip_cmp, valley_cmp,
			  supply_undervoltage, pump_undervoltage, current_limit,
			  stall_detected, learn_done, stall_report_i}),
		.q      (sy)
	);

	wire       s_step   = sy[18];
	wire       s_dir    = sy[17];
	wire       s_sleepn = sy[16];
	wire [1:0] s_m0     = sy[15:14];
	wire [1:0] s_m1     = sy[13:12];
	wire [1:0] s_stm    = sy[11:10];
	wire [1:0] s_en     = sy[9:8];
	wire       s_trip   = sy[7];
	wire       s_valley = sy[6];
	wire       s_supply_undervoltage   = sy[5];
	wire       s_pump_undervoltage   = sy[4];
	wire       s_ilim   = sy[3];
	wire       s_stall  = sy[2];
	wire       s_learn  = sy[1];
	wire       s_strep  = sy[0];

	// ---------------------------------------------------------------
	// level decode
	// ---------------------------------------------------------------
	function [1:0] tri_dec;
		input [1:0] p;
		begin
			tri_dec = p[1] ? `WCC_LVL_HIGH : (p[0] ? `WCC_LVL_LOW : `WCC_LVL_OPEN);
		end
	endfunction

	function [1:0] quad_dec;
		input [1:0] p;
		begin
			case (p)
				2'h1:    quad_dec = `WCC_LVL_LOW;
				2'h2:    quad_dec = `WCC_LVL_HIGH;
				2'h3:    quad_dec = `WCC_LVL_Q3;
				default: quad_dec = `WCC_LVL_OPEN;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// sine target
	// ---------------------------------------------------------------
	reg  [4:0]       idx_reg;
	reg              step_d_reg;
	wire [REF_W-1:0] tgt_mag;
	wire             tgt_neg;
	wire [REF_W+7:0] valley_prod = tgt_mag * valley_ratio;

	wcc_sine_lut #(.REF_W(REF_W)) u_lut (
		.idx       (idx_reg),
		.ref_level (current_ref_level),
		.mag       (tgt_mag),
		.neg       (tgt_neg)
	);

	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			idx_reg    <= `WCC_SINE_IDX_RST;
			step_d_reg <= 1'b0;
		end
		else
		begin
			step_d_reg <= s_step;
			if (!s_sleepn)
				idx_reg <= `WCC_SINE_IDX_RST;
			else if (s_step && !step_d_reg)
				idx_reg <= s_dir ? idx_reg + 5'h01 : idx_reg - 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// fault supervisor
	// ---------------------------------------------------------------
	localparam OC_OK    = 2'h0;
	localparam OC_TRIP  = 2'h1;
	localparam OC_RETRY = 2'h2;

	reg [1:0]  oc_state_reg;
	reg [31:0] oc_cnt_reg;
	wire       oc_glitch = (oc_cnt_reg >= `WCC_OCP_CYC - 1);

	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			oc_state_reg <= OC_OK;
			oc_cnt_reg   <= 32'h0;
		end
		else
			case (oc_state_reg)
				OC_OK:
				begin
					oc_cnt_reg <= s_ilim ? oc_cnt_reg + 32'h1 : 32'h0;
					if (s_ilim && oc_glitch)
					begin
						oc_state_reg <= OC_TRIP;
						oc_cnt_reg   <= 32'h0;
					end
				end
				OC_TRIP:
				begin
					oc_cnt_reg <= oc_cnt_reg + 32'h1;
					if (oc_cnt_reg >= RETRY_CYC - 1)
						oc_state_reg <= OC_RETRY;
				end
				default:
				begin
					oc_cnt_reg <= 32'h0;
					if (!s_ilim)
						oc_state_reg <= OC_OK;
				end
			endcase
	end

	wire oc_active  = (oc_state_reg != OC_OK);
	wire prot_fault = s_supply_undervoltage || s_pump_undervoltage || oc_active;
	wire stl_active = (tri_dec(s_stm) != `WCC_LVL_OPEN);
	// pad echo lags our own release by the synchroniser
	reg  [1:0] rel_hist_reg;
	wire stl_quiet  = !s_strep && !stall_report_oe && (rel_hist_reg == 2'h0);
	wire stl_fault  = stl_active && s_stall && !prot_fault && !stl_quiet;

	// ---------------------------------------------------------------
	// chopper
	// ---------------------------------------------------------------
	localparam CH_IDLE  = 2'h0;
	localparam CH_BLANK = 2'h1;
	localparam CH_DRIVE = 2'h2;
	localparam CH_DECAY = 2'h3;

	reg [1:0]  ch_state_reg;
	reg [7:0]  blank_cnt_reg;
	wire       run = s_sleepn && !prot_fault && (tri_dec(s_en) != `WCC_LVL_LOW);
	wire [3:0] drive_code = tgt_neg ? `WCC_GATE_REV : `WCC_GATE_FWD;
	reg  [3:0] gate_next;

	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			ch_state_reg  <= CH_IDLE;
			blank_cnt_reg <= 8'h00;
		end
		else if (!run)
			ch_state_reg <= CH_IDLE;
		else
			case (ch_state_reg)
				CH_IDLE:
				begin
					ch_state_reg  <= CH_BLANK;
					blank_cnt_reg <= 8'h00;
				end
				CH_BLANK:
				begin
					blank_cnt_reg <= blank_cnt_reg + 8'h01;
					if (blank_cnt_reg >= `WCC_BLANK_CYC - 1)
						ch_state_reg <= CH_DRIVE;
				end
				CH_DRIVE:
					if (s_trip)
						ch_state_reg <= CH_DECAY;
				default:
					if (s_valley)
					begin
						ch_state_reg  <= CH_BLANK;
						blank_cnt_reg <= 8'h00;
					end
			endcase
	end

	always @*
	begin
		gate_next = `WCC_GATE_OFF;
		if (run)
			case (ch_state_reg)
				CH_BLANK: gate_next = drive_code;
				CH_DRIVE: gate_next = s_trip ? `WCC_GATE_SLOW : drive_code;
				CH_DECAY: gate_next = `WCC_GATE_SLOW;
				default:  gate_next = `WCC_GATE_OFF;
			endcase
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			bridge_gate         <= `WCC_GATE_OFF;
			pump_enable         <= 1'b0;
			trip_level          <= {REF_W{1'b0}};
			valley_level        <= {REF_W{1'b0}};
			overcurrent_fault   <= 1'b0;
			stall_detect_enable <= 1'b0;
			step_size_sel0      <= `WCC_LVL_LOW;
			step_size_sel1      <= `WCC_LVL_LOW;
			stall_mode_sel      <= `WCC_LVL_LOW;
			enable_mode         <= `WCC_LVL_LOW;
			fault_n_out_o       <= 1'b0;
			fault_n_out_oe      <= 1'b0;
			stall_report_o      <= 1'b0;
			stall_report_oe     <= 1'b0;
			rel_hist_reg        <= 2'h0;
		end
		else
		begin
			bridge_gate         <= gate_next;
			pump_enable         <= s_sleepn && !s_supply_undervoltage;
			trip_level          <= tgt_mag;
			valley_level        <= valley_prod[REF_W+7:8];
			overcurrent_fault   <= oc_active;
			stall_detect_enable <= stl_active && !prot_fault;
			step_size_sel0      <= tri_dec(s_m0);
			step_size_sel1      <= quad_dec(s_m1);
			stall_mode_sel      <= tri_dec(s_stm);
			enable_mode         <= tri_dec(s_en);
			fault_n_out_oe      <= prot_fault || stl_fault;
			rel_hist_reg        <= {rel_hist_reg[0], stall_report_oe};
			if (!stl_active)
				stall_report_oe <= s_learn;
			else
				stall_report_oe <= !s_stall && !stl_quiet;
		end
	end
endmodule

// File: verilog/wcc_map.vh
/*
 constants for the winding current chopper and fault supervisor:
 timing figures, derived cycle counts, level codes and reset values.
 assumes a 250 MHz mclk.
*/
`ifndef WCC_MAP_VH
`define WCC_MAP_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WCC_CLK_MHZ          250
`define WCC_BLANK_NS         1000
`define WCC_BLANK_CYC        ((`WCC_BLANK_NS * `WCC_CLK_MHZ + 999) / 1000)
`define WCC_OCP_NS           2000
`define WCC_OCP_CYC          ((`WCC_OCP_NS * `WCC_CLK_MHZ + 999) / 1000)
`define WCC_RETRY_US         4000
`define WCC_RETRY_CYC        (`WCC_RETRY_US * `WCC_CLK_MHZ)

// ---------------------------------------------------------------
// multi-level pin codes
// ---------------------------------------------------------------
`define WCC_LVL_LOW          2'h0
`define WCC_LVL_HIGH         2'h1
`define WCC_LVL_OPEN         2'h2
`define WCC_LVL_Q3           2'h3

// ---------------------------------------------------------------
// bridge gate codes {hs_a, ls_a, hs_b, ls_b}
// ---------------------------------------------------------------
`define WCC_GATE_OFF         4'h0
`define WCC_GATE_SLOW        4'h5
`define WCC_GATE_FWD         4'h9
`define WCC_GATE_REV         4'h6

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WCC_SINE_IDX_RST     5'h00
`define WCC_VALLEY_NUM_RST   8'hE0

`endif

// File: verilog/wcc_sync.v
/*
 two flip-flop synchroniser for a bundle of pin levels.
 assumes inputs are asynchronous to mclk.
*/
`timescale 1ns/1ns
module wcc_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         mclk,
	input  wire         resetn,
	// levels
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule

// File: verilog/wcc_sine_lut.v
/*
 sine-weighted current table, one quadrant of 1/8 steps scaled
 by the full-scale reference level.
 assumes idx counts 1/8 steps over a full electrical cycle (0..31).
*/
`timescale 1ns/1ns
module wcc_sine_lut #(
	parameter REF_W = 8
) (
	// table index and reference
	input  wire [4:0]       idx,
	input  wire [REF_W-1:0] ref_level,
	// signed target
	output wire [REF_W-1:0] mag,
	output wire             neg
);
	reg  [6:0]         pct;
	wire [2:0]         q_pos;
	wire [REF_W+6:0]   prod;
	wire [REF_W+6:0]   quo;

	// 8 entries per quadrant, mirrored on odd quadrants
	assign q_pos = idx[3] ? (3'h0 - idx[2:0]) : idx[2:0];

	always @*
	begin
		pct = 7'h00;
		if (idx[3] && idx[2:0] == 3'h0)
			pct = 7'h00;
		else if (!idx[3] && idx[2:0] == 3'h0)
			pct = 7'h00;
		else
			case (q_pos)
				3'h1: pct = 7'h14;
				3'h2: pct = 7'h26;
				3'h3: pct = 7'h38;
				3'h4: pct = 7'h47;
				3'h5: pct = 7'h53;
				3'h6: pct = 7'h5C;
				default: pct = 7'h62;
			endcase
		if (idx[3:0] == 4'h8)
			pct = 7'h64;
	end

	assign prod = ref_level * pct;
	assign quo  = prod / 7'h64;
	assign mag  = quo[REF_W-1:0];
	assign neg  = idx[4];
endmodule

// File: dv/wcc_winding_model.sv
/*
 winding, bridge and comparator model for the chopper, plus the
 pulled-up stall report line.
 assumes bridge_gate codes from wcc_map.vh.
*/
`timescale 1ns/1ns
`include "wcc_map.vh"
module wcc_winding_model (
	// clock
	input	wire		mclk,
	// bridge side
	input	wire [3:0]	bridge_gate,
	input	wire [7:0]	trip_level,
	input	wire [7:0]	valley_level,
	input	wire [3:0]	rise,
	output	reg		trip_cmp,
	output	reg		valley_cmp,
	// stall report line
	input	wire		stall_report_oe,
	input	wire		hold_low,
	output	wire		stall_report_i
);
	integer cur;
	initial
	begin
		cur = 0;
		trip_cmp = 1'b0;
		valley_cmp = 1'b0;
	end
	// drive pushes current, both low sides let it sag
	always @(posedge mclk)
	begin
		if (bridge_gate == `WCC_GATE_FWD || bridge_gate == `WCC_GATE_REV)
			cur = cur + rise;
		else if (bridge_gate == `WCC_GATE_SLOW && cur > 0)
			cur = cur - 1;
		else if (bridge_gate == `WCC_GATE_OFF)
			cur = 0;
		trip_cmp <= cur >= trip_level * 16;
		valley_cmp <= cur <= valley_level * 16;
	end
	// open drain with pull-up, may be held low from outside
	assign stall_report_i = !(stall_report_oe || hold_low);
endmodule

// File: dv/wcc_chopper_ctrl_sva.sv
/*
 checker for the chopper and fault supervisor ports.
 assumes one mclk domain and sync active-low resetn.
*/
`timescale 1ns/1ns
`include "wcc_map.vh"
module wcc_chk #(
	parameter RETRY_CYC = 50
) (
	// clock and reset
	input	wire		mclk,
	input	wire		resetn,
	// inputs watched
	input	wire		sleep_n,
	input	wire		trip_cmp,
	input	wire		valley_cmp,
	input	wire		supply_undervoltage,
	input	wire		pump_undervoltage,
	input	wire		current_limit,
	// outputs watched
	input	wire [3:0]	bridge_gate,
	input	wire		pump_enable,
	input	wire		overcurrent_fault,
	input	wire		stall_detect_enable,
	input	wire		fault_n_out_oe
);
	reg [15:0]	drv_reg;
	reg [15:0]	lim_reg;
	reg [19:0]	age_reg;
	wire		drv = bridge_gate == `WCC_GATE_FWD || bridge_gate == `WCC_GATE_REV;
	// run lengths of drive, current limit and overcurrent fault
	always @(posedge mclk)
	begin
		drv_reg <= (!resetn || !drv) ? 16'h0000 : drv_reg + 16'h0001;
		lim_reg <= (!resetn || !current_limit) ? 16'h0000 : lim_reg + 16'h0001;
		age_reg <= (!resetn || !overcurrent_fault) ? 20'h00000 : age_reg + 20'h00001;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence trip_seen;
		drv && drv_reg >= 16'd260 && trip_cmp;
	endsequence
	sequence valley_quiet;
		!valley_cmp [*3];
	endsequence
	sequence valley_seen;
		valley_cmp [*3];
	endsequence
	gate_codes_a: assert property (drv || bridge_gate == `WCC_GATE_OFF ||
		bridge_gate == `WCC_GATE_SLOW) else $error("illegal bridge code");
	min_drive_a: assert property ($fell(drv) && bridge_gate == `WCC_GATE_SLOW
		|-> drv_reg >= 16'd250) else $error("drive shorter than blank");
	trip_decay_a: assert property (trip_seen |-> ##[1:4] !drv)
		else $error("no decay after trip");
	decay_hold_a: assert property (valley_quiet ##0 bridge_gate == `WCC_GATE_SLOW
		|=> !drv) else $error("decay left before valley");
	valley_end_a: assert property (valley_seen ##0 bridge_gate == `WCC_GATE_SLOW
		|-> ##[1:3] bridge_gate != `WCC_GATE_SLOW) else $error("decay stuck at valley");
	supply_uv_a: assert property (supply_undervoltage [*4] |-> fault_n_out_oe &&
		bridge_gate == `WCC_GATE_OFF && !pump_enable) else $error("supply uv not handled");
	pump_uv_a: assert property ((pump_undervoltage && sleep_n && !supply_undervoltage) [*4]
		|-> fault_n_out_oe && bridge_gate == `WCC_GATE_OFF && pump_enable)
		else $error("pump uv not handled");
	oc_deglitch_a: assert property ($rose(overcurrent_fault) |-> lim_reg >= 16'd500)
		else $error("overcurrent too early");
	oc_set_a: assert property (lim_reg >= 16'd504 |-> overcurrent_fault)
		else $error("overcurrent missed");
	oc_gate_a: assert property (overcurrent_fault && $past(overcurrent_fault) |->
		fault_n_out_oe && bridge_gate == `WCC_GATE_OFF && !stall_detect_enable)
		else $error("overcurrent outputs wrong");
	oc_retry_a: assert property ($fell(overcurrent_fault) |-> age_reg >= RETRY_CYC &&
		!$past(current_limit, 4)) else $error("retry too early");
endmodule
bind wcc_chopper_ctrl wcc_chk #(.RETRY_CYC(RETRY_CYC)) u_chk (.mclk(mclk), .resetn(resetn),
	.sleep_n(sleep_n), .trip_cmp(trip_cmp), .valley_cmp(valley_cmp),
	.supply_undervoltage(supply_undervoltage), .pump_undervoltage(pump_undervoltage),
	.current_limit(current_limit), .bridge_gate(bridge_gate), .pump_enable(pump_enable),
	.overcurrent_fault(overcurrent_fault), .stall_detect_enable(stall_detect_enable),
	.fault_n_out_oe(fault_n_out_oe));

// File: dv/tb_winding_current_chopper_fault_ctrl.sv
/*
 self-checking bench for the chopper and fault supervisor.
 assumes the winding model and the checker are compiled with it.
*/
`timescale 1ns/1ns
`include "wcc_map.vh"
module tb_winding_current_chopper_fault_ctrl;
	reg		mclk = 0, resetn = 0, step = 0, dir = 1, sleep_n = 0;
	reg [1:0]	p0 = 2'h2, p1 = 2'h2, pm = 2'h2, pe = 2'h2;
	reg [7:0]	ref_lvl = 8'h00, ratio = 8'h00;
	reg		s_uv = 0, p_uv = 0, c_lim = 0, stall = 0, learn = 0, hold = 0;
	reg [3:0]	rise = 4'h4;
	reg [31:0]	r;
	wire [3:0]	gate;
	wire [7:0]	trip, valley;
	wire [1:0]	s0, s1, sm, em;
	wire		tc, vc, pump, ocf, sde, f_oe, sr_i, sr_oe, fo_o, sr_o;
	integer		n_errors = 0, n_checks = 0, seed = 32'h8627, i, exp_idx = 0;
	wire		in_dec = gate === `WCC_GATE_SLOW;
	wire		in_drv = gate === `WCC_GATE_FWD || gate === `WCC_GATE_REV;

	initial
	begin
		forever #2 mclk = ~mclk;
	end
	wcc_chopper_ctrl #(.RETRY_CYC(50)) dut (.mclk(mclk), .resetn(resetn), .step(step),
		.direction(dir), .sleep_n(sleep_n), .step_size_sel0_pad(p0), .step_size_sel1_pad(p1),
		.stall_mode_sel_pad(pm), .enable_pad(pe), .current_ref_level(ref_lvl),
		.valley_ratio(ratio), .trip_cmp(tc), .valley_cmp(vc), .supply_undervoltage(s_uv),
		.pump_undervoltage(p_uv), .current_limit(c_lim), .stall_detected(stall),
		.learn_done(learn), .bridge_gate(gate), .pump_enable(pump), .trip_level(trip),
		.valley_level(valley), .overcurrent_fault(ocf), .stall_detect_enable(sde),
		.step_size_sel0(s0), .step_size_sel1(s1), .stall_mode_sel(sm), .enable_mode(em),
		.fault_n_out_o(fo_o), .fault_n_out_oe(f_oe), .stall_report_i(sr_i),
		.stall_report_o(sr_o),
		.stall_report_oe(sr_oe));
	wcc_winding_model u_wind (.mclk(mclk), .bridge_gate(gate), .trip_level(trip),
		.valley_level(valley), .rise(rise), .trip_cmp(tc), .valley_cmp(vc),
		.stall_report_oe(sr_oe), .hold_low(hold), .stall_report_i(sr_i));

	// expected decodes of the level pins
	function [1:0] tri_dec(input [1:0] p);
		tri_dec = p[1] ? 2'h1 : (p[0] ? 2'h0 : 2'h2);
	endfunction
	function [1:0] quad_dec(input [1:0] p);
		quad_dec = (p == 2'h1) ? 2'h0 : (p == 2'h2) ? 2'h1 : (p == 2'h3) ? 2'h3 : 2'h2;
	endfunction
	// expected sine weight in percent for a 1/8 step index
	function integer sine_pct(input integer k);
		integer q;
	begin
		q = k % 16;
		if (q > 8)
			q = 16 - q;
		case (q)
			0: sine_pct = 0;
			1: sine_pct = 20;
			2: sine_pct = 38;
			3: sine_pct = 56;
			4: sine_pct = 71;
			5: sine_pct = 83;
			6: sine_pct = 92;
			7: sine_pct = 98;
			default: sine_pct = 100;
		endcase
	end
	endfunction
	task chk(input [8*12-1:0] name, input [31:0] seen, input [31:0] exp);
	begin
		n_checks = n_checks + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("[FAIL] %0s expected %0h seen %0h", name, exp, seen);
		end
	end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge mclk);
	endtask
	task pulse(input d);
	begin
		dir = d;
		step = 1;
		cyc(4);
		step = 0;
		cyc(4);
		exp_idx = (exp_idx + (d ? 1 : 31)) % 32;
		chk("trip_step", trip, ref_lvl * sine_pct(exp_idx) / 100);
		chk("valley_step", valley, (ref_lvl * sine_pct(exp_idx) / 100) * ratio / 256);
	end
	endtask
	task wait_gate(input dec);
		integer k;
	begin
		k = 0;
		while (!(dec ? in_dec : in_drv) && k < 5000)
		begin
			cyc(1);
			k = k + 1;
		end
		chk("gate_phase", dec ? in_dec : in_drv, 1);
	end
	endtask
	task final_report;
	begin
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	initial
	begin
		#400000;
		n_errors = n_errors + 1;
		final_report;
	end
	initial
	begin
		cyc(20);
		resetn = 1;
		sleep_n = 1;
		cyc(4);
		chk("fault_rel", f_oe, 0);
		chk("trip_idx0", trip, 0);
		chk("od_low", {fo_o, sr_o}, 2'h0);
		$display("reset test done");
		for (i = 0; i < 4; i = i + 1)
		begin
			{p0, p1, pm, pe} = {4{i[1:0]}};
			cyc(4);
			chk("modes", {s0, s1, sm, em}, {tri_dec(i[1:0]), quad_dec(i[1:0]),
				tri_dec(i[1:0]), tri_dec(i[1:0])});
		end
		{p0, p1, pm, pe} = 8'hAA;
		$display("mode test done");
		r = $random(seed);
		ref_lvl = 8'h40 + {1'b0, r[6:0]};
		ratio = 8'hC0 + {3'h0, r[12:8]};
		for (i = 0; i < 8; i = i + 1)
			pulse(1);
		chk("trip_90", trip, ref_lvl);
		chk("valley", valley, ({8'h00, ref_lvl} * ratio) >> 8);
		wait_gate(1);
		wait_gate(0);
		chk("drive_fwd", gate, `WCC_GATE_FWD);
		wait_gate(1);
		rise = 4'hF;
		wait_gate(0);
		wait_gate(1);
		rise = 4'h4;
		for (i = 0; i < 16; i = i + 1)
			pulse(0);
		chk("trip_270", trip, ref_lvl);
		wait_gate(0);
		chk("drive_rev", gate, `WCC_GATE_REV);
		$display("chop test done");
		s_uv = 1;
		cyc(4);
		chk("uv", {f_oe, gate, pump, sde}, {1'b1, `WCC_GATE_OFF, 2'h0});
		s_uv = 0;
		cyc(4);
		chk("uv_clear", {f_oe, pump}, 2'h1);
		p_uv = 1;
		cyc(4);
		chk("pump_undervoltage", {f_oe, gate, pump}, {1'b1, `WCC_GATE_OFF, 1'b1});
		p_uv = 0;
		cyc(4);
		chk("pump_undervoltage_clear", f_oe, 0);
		c_lim = 1;
		cyc(490);
		chk("oc_early", ocf, 0);
		cyc(20);
		chk("oc_set", {ocf, f_oe, gate}, {2'h3, `WCC_GATE_OFF});
		cyc(100);
		chk("oc_held", ocf, 1);
		c_lim = 0;
		cyc(4);
		chk("oc_clear", {ocf, f_oe}, 0);
		$display("fault test done");
		stall = 1;
		cyc(4);
		chk("stall_rep", {f_oe, sr_oe}, 2'h2);
		stall = 0;
		hold = 1;
		cyc(4);
		stall = 1;
		cyc(12);
		chk("stall_mask", f_oe, 0);
		stall = 0;
		hold = 0;
		pm = 2'h0;
		learn = 1;
		cyc(4);
		chk("learn_ok", sr_oe, 1);
		$display("stall test done");
		final_report;
	end
endmodule
